// *** hw/tmr8_wave_ctrl.sv ***
// Purpose: 8-bit timer with two compare channels, waveform modes and pin muxing.
// Assumes: Port direction and port data come from same-clock logic; t0 pin is async.
// Notes:   Compare flags and interrupt masks live in a neighbouring block.
//
// Contract
// RQ1: A nonzero channel action field hands the pin to the waveform output.
// RQ2: Pin driver enable follows the port direction bit only.
// RQ3: Non-PWM channel A codes: off, toggle, clear, set on match.
// RQ4: Non-PWM channel B uses the same codes at bits five to four.
// RQ5: Fast PWM channel A: code 2 clear-match set-top, code 3 opposite.
// RQ6: PWM channel A code 1 toggles on match only when mode high bit set.
// RQ7: Fast PWM channel B code 1 reserved; codes 2 and 3 as channel A.
// RQ8: Phase-correct channel A: code 2 clears counting up, sets counting down.
// RQ9: Phase-correct channel B code 1 reserved; codes 2 and 3 as channel A.
// RQ10: Channel A compare equal to TOP in PWM acts at TOP, ignores match.
// RQ11: Channel B compare equal to TOP in PWM acts at TOP, ignores match.
// RQ12: Reserved control bits read zero and ignore writes.
// RQ13: Mode is high bit from control B and low bits from control A.
// RQ14: Normal TOP 0xFF, clear-on-match TOP compare A, immediate update, overflow at MAX.
// RQ15: Phase-correct overflow at BOTTOM, fast PWM at MAX or TOP, PWM updates at TOP.
// RQ16: Force strobes act only in non-PWM modes.
// RQ17: Software keeps force bits zero when writing control B in PWM.
// RQ18: A force strobe is an immediate match using the present action code.
// RQ19: A forced match raises no flag and never clears the counter.
// RQ20: Force bits are write-only strobes that read as zero.
// RQ21: Clock select picks stop, divide 1/8/64/256/1024, or external falling/rising edge.
// RQ22: Phase-correct counts up to TOP, then down to BOTTOM, TOP held once.
// RQ23: Reserved modes and channel B code 1 in PWM leave pins disconnected safely.
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module tmr8_wave_ctrl
  import tmr8_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic [2:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  input  wire logic       ext_clk_pin_i,
  input  wire logic [1:0] port_dir_i,
  input  wire logic [1:0] port_data_i,
  output logic      [1:0] pin_out_o,
  output logic      [1:0] pin_oe_o,
  output logic      [1:0] match_o,
  output logic            overflow_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // Control registers.
  logic [7:0]   ctrl_a_reg;
  logic [7:0]   ctrl_b_reg;
  logic [7:0]   cnt_reg;
  logic [7:0]   cmp_buf_reg [2];
  logic [7:0]   cmp_act_reg [2];
  logic [1:0]   wave_reg;
  logic [1:0]   wave_next;
  tmr8_dir_t    dir_reg;
  tmr8_wmode_t  wmode;
  tmr8_clksel_t clksel;
  logic         wr_a;
  logic         wr_b;
  logic         wr_cnt;
  logic         is_pwm;
  logic         is_fast;
  logic         is_pc;
  logic         is_rsv;
  logic         top_is_cmp;
  logic [7:0]   top_val;
  logic         at_top;
  logic         tick;
  logic         ovf_ev;
  logic         block_reg;
  logic [1:0]   hit;
  logic [1:0]   force_ev;
  logic [1:0]   connected;
  logic [1:0]   act [2];

  assign wr_a   = wr_i && (addr_i == TMR8_OFS_CTRL_A);
  assign wr_b   = wr_i && (addr_i == TMR8_OFS_CTRL_B);
  assign wr_cnt = wr_i && (addr_i == TMR8_OFS_COUNT);

  // Masking on write keeps reserved and strobe bits permanently zero.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_a_reg <= TMR8_CTRL_A_RST;
    end else if (wr_a) begin
      ctrl_a_reg <= wdata_i & TMR8_CTRL_A_WMASK; // RQ12
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_b_reg <= TMR8_CTRL_B_RST;
    end else if (wr_b) begin
      ctrl_b_reg <= wdata_i & TMR8_CTRL_B_WMASK; // RQ12 RQ20
    end
  end

  assign wmode = tmr8_wmode_t'({ctrl_b_reg[TMR8_MODE_HI_BIT],
                                ctrl_a_reg[TMR8_MODE_LOW_LSB +: 2]}); // RQ13
  assign clksel     = tmr8_clksel_t'(ctrl_b_reg[TMR8_CLKSEL_LSB +: 3]);
  assign act[0]     = ctrl_a_reg[TMR8_ACT_A_LSB +: 2];
  assign act[1]     = ctrl_a_reg[TMR8_ACT_B_LSB +: 2];
  assign is_fast    = (wmode == TMR8_WM_FAST_FF) || (wmode == TMR8_WM_FAST_CMP);
  assign is_pc      = (wmode == TMR8_WM_PC_FF) || (wmode == TMR8_WM_PC_CMP);
  assign is_pwm     = is_fast || is_pc;
  assign is_rsv     = (wmode == TMR8_WM_RSV4) || (wmode == TMR8_WM_RSV6); // RQ23
  assign top_is_cmp = (wmode == TMR8_WM_CLR) || (wmode == TMR8_WM_PC_CMP)
                      || (wmode == TMR8_WM_FAST_CMP); // RQ14 RQ15
  assign top_val    = top_is_cmp ? cmp_act_reg[0] : TMR8_MAX;
  assign at_top     = (cnt_reg == top_val);

  ////////////////////////////////////////////////////////////////////////////////
  // Prescaler and external clock input.
  logic [TMR8_PRE_W-1:0] pre_reg;
  logic                  ext_s1_reg;
  logic                  ext_s2_reg;
  logic                  ext_s3_reg;
  logic                  ext_lvl_reg;
  logic                  ext_stable;
  logic                  ext_rise;
  logic                  ext_fall;

  // Free running, so a ratio change takes effect without a restart.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
    end else begin
      ext_s1_reg <= ext_clk_pin_i;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end

  assign ext_stable = (ext_s2_reg == ext_s3_reg);
  assign ext_rise   = ext_stable && ext_s2_reg && !ext_lvl_reg;
  assign ext_fall   = ext_stable && !ext_s2_reg && ext_lvl_reg;

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ext_lvl_reg <= 1'b0;
    end else if (ext_stable) begin
      ext_lvl_reg <= ext_s2_reg;
    end
  end

  always_comb begin
    case (clksel)
      TMR8_CS_OFF:      tick = 1'b0; // RQ21
      TMR8_CS_DIV1:     tick = 1'b1; // RQ21
      TMR8_CS_DIV8:     tick = &pre_reg[TMR8_DIV8_BITS-1:0]; // RQ21
      TMR8_CS_DIV64:    tick = &pre_reg[TMR8_DIV64_BITS-1:0]; // RQ21
      TMR8_CS_DIV256:   tick = &pre_reg[TMR8_DIV256_BITS-1:0]; // RQ21
      TMR8_CS_DIV1024:  tick = &pre_reg[TMR8_DIV1024_BITS-1:0]; // RQ21
      TMR8_CS_EXT_FALL: tick = ext_fall; // RQ21
      TMR8_CS_EXT_RISE: tick = ext_rise; // RQ21
      default:          tick = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counter and count direction.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cnt_reg <= TMR8_COUNT_RST;
    end else if (wr_cnt) begin
      cnt_reg <= wdata_i;
    end else if (tick) begin
      case (wmode)
        TMR8_WM_NORMAL: begin
          cnt_reg <= cnt_reg + 8'h01; // RQ14
        end
        TMR8_WM_CLR, TMR8_WM_FAST_FF, TMR8_WM_FAST_CMP: begin
          cnt_reg <= at_top ? TMR8_BOTTOM : cnt_reg + 8'h01; // RQ14 RQ15
        end
        TMR8_WM_PC_FF, TMR8_WM_PC_CMP: begin
          if (dir_reg == TMR8_DIR_UP) begin
            if (at_top) begin
              cnt_reg <= (cnt_reg == TMR8_BOTTOM) ? TMR8_BOTTOM : cnt_reg - 8'h01; // RQ22
            end else begin
              cnt_reg <= cnt_reg + 8'h01; // RQ22
            end
          end else if (cnt_reg == TMR8_BOTTOM) begin
            cnt_reg <= at_top ? TMR8_BOTTOM : cnt_reg + 8'h01; // RQ22
          end else begin
            cnt_reg <= cnt_reg - 8'h01; // RQ22
          end
        end
        default: begin
          cnt_reg <= TMR8_BOTTOM; // RQ23
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dir_reg <= TMR8_DIR_UP;
    end else if (!is_pc) begin
      dir_reg <= TMR8_DIR_UP;
    end else if (tick) begin
      case (dir_reg)
        TMR8_DIR_UP:   dir_reg <= at_top ? TMR8_DIR_DOWN : TMR8_DIR_UP; // RQ22
        TMR8_DIR_DOWN: dir_reg <= (cnt_reg == TMR8_BOTTOM) ? TMR8_DIR_UP : TMR8_DIR_DOWN;
        default:       dir_reg <= TMR8_DIR_UP;
      endcase
    end
  end

  // A counter write suppresses the compare match on the next timer clock.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      block_reg <= 1'b0;
    end else if (wr_cnt) begin
      block_reg <= 1'b1;
    end else if (tick) begin
      block_reg <= 1'b0;
    end
  end

  always_comb begin
    ovf_ev = 1'b0;
    if (tick) begin
      case (wmode)
        TMR8_WM_NORMAL, TMR8_WM_CLR, TMR8_WM_FAST_FF: ovf_ev = (cnt_reg == TMR8_MAX); // RQ14 RQ15
        TMR8_WM_FAST_CMP: ovf_ev = at_top; // RQ15
        TMR8_WM_PC_FF, TMR8_WM_PC_CMP: ovf_ev = (dir_reg == TMR8_DIR_DOWN)
                                                && (cnt_reg == TMR8_BOTTOM); // RQ15
        default: ovf_ev = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      overflow_o <= 1'b0;
    end else begin
      overflow_o <= ovf_ev;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare channels.
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_chan
      logic tgl_ok;
      logic top_act;
      logic ocr_eq_top;
      logic force_bit;

      assign force_bit  = (ch == 0) ? wdata_i[TMR8_FORCE_A_BIT] : wdata_i[TMR8_FORCE_B_BIT];
      assign force_ev[ch] = wr_b && force_bit && !is_pwm; // RQ16 RQ18
      assign hit[ch]    = tick && (cnt_reg == cmp_act_reg[ch]) && !block_reg;
      // Only channel A has the toggle option in PWM, and only with the mode high bit.
      assign tgl_ok     = (ch == 0) && ctrl_b_reg[TMR8_MODE_HI_BIT]; // RQ6 RQ7 RQ9
      assign ocr_eq_top = (cmp_act_reg[ch] == top_val);
      assign top_act    = tick && at_top;
      assign connected[ch] = !is_rsv && (act[ch] != TMR8_ACT_OFF)
                             && !(is_pwm && (act[ch] == TMR8_ACT_TOGGLE) && !tgl_ok); // RQ1 RQ23

      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          cmp_buf_reg[ch] <= TMR8_CMP_RST;
        end else if (wr_i && (addr_i == ((ch == 0) ? TMR8_OFS_CMP_A : TMR8_OFS_CMP_B))) begin
          cmp_buf_reg[ch] <= wdata_i;
        end
      end

      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          cmp_act_reg[ch] <= TMR8_CMP_RST;
        end else if (!is_pwm || top_act) begin
          cmp_act_reg[ch] <= cmp_buf_reg[ch]; // RQ14 RQ15
        end
      end

      always_comb begin
        wave_next[ch] = wave_reg[ch];
        if (!is_pwm && !is_rsv) begin
          if (hit[ch] || force_ev[ch]) begin // RQ18
            case (act[ch])
              TMR8_ACT_TOGGLE: wave_next[ch] = !wave_reg[ch]; // RQ3 RQ4
              TMR8_ACT_CLEAR:  wave_next[ch] = 1'b0; // RQ3 RQ4
              TMR8_ACT_SET:    wave_next[ch] = 1'b1; // RQ3 RQ4
              default:         wave_next[ch] = wave_reg[ch];
            endcase
          end
        end else if (is_pwm && (act[ch] == TMR8_ACT_TOGGLE)) begin
          if (tgl_ok && hit[ch]) begin
            wave_next[ch] = !wave_reg[ch]; // RQ6
          end
        end else if (is_fast && act[ch][1]) begin
          if (top_act) begin
            wave_next[ch] = !act[ch][0]; // RQ5 RQ7 RQ10 RQ11
          end else if (hit[ch] && !ocr_eq_top) begin
            wave_next[ch] = act[ch][0]; // RQ5 RQ7
          end
        end else if (is_pc && act[ch][1]) begin
          if (ocr_eq_top) begin
            if (top_act) begin
              wave_next[ch] = !act[ch][0]; // RQ10 RQ11
            end
          end else if (hit[ch]) begin
            wave_next[ch] = (dir_reg == TMR8_DIR_UP) ? act[ch][0] : !act[ch][0]; // RQ8 RQ9
          end
        end
      end

      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          wave_reg[ch] <= 1'b0;
        end else begin
          wave_reg[ch] <= wave_next[ch];
        end
      end

      // Forced matches are kept off the match event so no flag is raised.
      always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          match_o[ch]   <= 1'b0;
          pin_out_o[ch] <= 1'b0;
          pin_oe_o[ch]  <= 1'b0;
        end else begin
          match_o[ch]   <= hit[ch]; // RQ19
          pin_out_o[ch] <= connected[ch] ? wave_reg[ch] : port_data_i[ch]; // RQ1
          pin_oe_o[ch]  <= port_dir_i[ch]; // RQ2
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Register read port.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        TMR8_OFS_CTRL_A: rdata_o <= ctrl_a_reg & TMR8_CTRL_A_WMASK; // RQ12
        TMR8_OFS_CTRL_B: rdata_o <= ctrl_b_reg & TMR8_CTRL_B_WMASK; // RQ20
        TMR8_OFS_COUNT:  rdata_o <= cnt_reg;
        TMR8_OFS_CMP_A:  rdata_o <= cmp_buf_reg[0];
        TMR8_OFS_CMP_B:  rdata_o <= cmp_buf_reg[1];
        default:         rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence s_force_a_pwm;
    wr_b && wdata_i[TMR8_FORCE_A_BIT] && is_pwm && !hit[0] && !(tick && at_top);
  endsequence

  sequence s_force_a_quiet;
    wr_b && wdata_i[TMR8_FORCE_A_BIT] && !is_pwm && !hit[0];
  endsequence

  AST_RSV_READ_ZERO: assert property ( // RQ12
    @(posedge clk_i) disable iff (!rstn_i)
    rd_i && (addr_i == TMR8_OFS_CTRL_A) |=> (rdata_o[3:2] == 2'b00))
    else $error("Reserved control bits read nonzero.");

  AST_FORCE_READ_ZERO: assert property ( // RQ20
    @(posedge clk_i) disable iff (!rstn_i)
    rd_i && (addr_i == TMR8_OFS_CTRL_B) |=> (rdata_o[7:4] == 4'h0))
    else $error("Force or reserved bits read nonzero.");

  AST_OE_FOLLOWS_DIR: assert property ( // RQ2
    @(posedge clk_i) disable iff (!rstn_i)
    ##1 (pin_oe_o == $past(port_dir_i)))
    else $error("Pin enable does not follow direction bit.");

  AST_FORCE_IGNORED_PWM: assert property ( // RQ16
    @(posedge clk_i) disable iff (!rstn_i)
    s_force_a_pwm |=> $stable(wave_reg[0]))
    else $error("Force strobe acted in a PWM mode.");

  AST_FORCE_NO_FLAG: assert property ( // RQ19
    @(posedge clk_i) disable iff (!rstn_i)
    s_force_a_quiet |=> !match_o[0] ##1 (!match_o[0] || $past(hit[0])))
    else $error("Forced compare raised a match event.");

  AST_FORCE_TOGGLE: assert property ( // RQ18
    @(posedge clk_i) disable iff (!rstn_i)
    (s_force_a_quiet and (!is_rsv && (act[0] == TMR8_ACT_TOGGLE)))
    |=> (wave_reg[0] != $past(wave_reg[0])))
    else $error("Forced toggle did not change the output.");

  AST_FAST_CLEAR_MATCH: assert property ( // RQ5
    @(posedge clk_i) disable iff (!rstn_i)
    is_fast && (act[0] == TMR8_ACT_CLEAR) && hit[0] && !at_top && (cmp_act_reg[0] != top_val)
    |=> !wave_reg[0])
    else $error("Fast PWM clear on match failed.");

  AST_PC_TURN_AT_TOP: assert property ( // RQ22
    @(posedge clk_i) disable iff (!rstn_i)
    is_pc && tick && !wr_cnt && at_top && (cnt_reg != TMR8_BOTTOM) && (dir_reg == TMR8_DIR_UP)
    |=> (dir_reg == TMR8_DIR_DOWN) && (cnt_reg == $past(cnt_reg) - 8'h01))
    else $error("Phase-correct counter did not turn at TOP.");

  AST_PC_OVF_BOTTOM: assert property ( // RQ15
    @(posedge clk_i) disable iff (!rstn_i)
    overflow_o && $past(is_pc) |-> ($past(cnt_reg) == TMR8_BOTTOM))
    else $error("Phase-correct overflow away from BOTTOM.");

  AST_RSV_DISCONNECT: assert property ( // RQ23
    @(posedge clk_i) disable iff (!rstn_i)
    is_rsv |=> (pin_out_o == $past(port_data_i)))
    else $error("Reserved mode drove a waveform onto a pin.");

endmodule

// *** pkg/tmr8_pkg.sv ***
// Purpose: Shared constants and types of the 8-bit timer waveform control block.
// Assumes: Registers are reached over a plain strobe port with a 3-bit address.
// Notes:   Channel index 0 is compare channel A, index 1 is compare channel B.
package tmr8_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map.
  localparam logic [2:0] TMR8_OFS_CTRL_A   = 3'h0;
  localparam logic [2:0] TMR8_OFS_CTRL_B   = 3'h1;
  localparam logic [2:0] TMR8_OFS_COUNT    = 3'h2;
  localparam logic [2:0] TMR8_OFS_CMP_A    = 3'h3;
  localparam logic [2:0] TMR8_OFS_CMP_B    = 3'h4;

  // Field positions.
  localparam int         TMR8_ACT_A_LSB    = 6;
  localparam int         TMR8_ACT_B_LSB    = 4;
  localparam int         TMR8_MODE_LOW_LSB = 0;
  localparam int         TMR8_FORCE_A_BIT  = 7;
  localparam int         TMR8_FORCE_B_BIT  = 6;
  localparam int         TMR8_MODE_HI_BIT  = 3;
  localparam int         TMR8_CLKSEL_LSB   = 0;

  // Writable bits; everything else is reserved or a strobe and reads zero.
  localparam logic [7:0] TMR8_CTRL_A_WMASK = 8'hf3;
  localparam logic [7:0] TMR8_CTRL_B_WMASK = 8'h0f;

  // Reset values.
  localparam logic [7:0] TMR8_CTRL_A_RST   = 8'h00;
  localparam logic [7:0] TMR8_CTRL_B_RST   = 8'h00;
  localparam logic [7:0] TMR8_COUNT_RST    = 8'h00;
  localparam logic [7:0] TMR8_CMP_RST      = 8'h00;

  // Counter extremes.
  localparam logic [7:0] TMR8_MAX          = 8'hff;
  localparam logic [7:0] TMR8_BOTTOM       = 8'h00;

  // Prescaler: low bits that must all be one for each divide ratio.
  localparam int         TMR8_PRE_W        = 10;
  localparam int         TMR8_DIV8_BITS    = 3;
  localparam int         TMR8_DIV64_BITS   = 6;
  localparam int         TMR8_DIV256_BITS  = 8;
  localparam int         TMR8_DIV1024_BITS = 10;

  ////////////////////////////////////////////////////////////////////////////////
  // Types.
  typedef enum logic [2:0] {
    TMR8_WM_NORMAL   = 3'h0,
    TMR8_WM_PC_FF    = 3'h1,
    TMR8_WM_CLR      = 3'h2,
    TMR8_WM_FAST_FF  = 3'h3,
    TMR8_WM_RSV4     = 3'h4,
    TMR8_WM_PC_CMP   = 3'h5,
    TMR8_WM_RSV6     = 3'h6,
    TMR8_WM_FAST_CMP = 3'h7
  } tmr8_wmode_t;

  typedef enum logic [2:0] {
    TMR8_CS_OFF      = 3'h0,
    TMR8_CS_DIV1     = 3'h1,
    TMR8_CS_DIV8     = 3'h2,
    TMR8_CS_DIV64    = 3'h3,
    TMR8_CS_DIV256   = 3'h4,
    TMR8_CS_DIV1024  = 3'h5,
    TMR8_CS_EXT_FALL = 3'h6,
    TMR8_CS_EXT_RISE = 3'h7
  } tmr8_clksel_t;

  typedef enum logic [1:0] {
    TMR8_ACT_OFF     = 2'h0,
    TMR8_ACT_TOGGLE  = 2'h1,
    TMR8_ACT_CLEAR   = 2'h2,
    TMR8_ACT_SET     = 2'h3
  } tmr8_action_t;

  typedef enum logic [1:0] {
    TMR8_DIR_UP      = 2'b01,
    TMR8_DIR_DOWN    = 2'b10
  } tmr8_dir_t;

endpackage

// *** testbench/tmr8_pin_model.sv ***
// Purpose: Pad model for the two compare output pins of the timer.
// Assumes: Each pad carries a board pull-up.
// Notes:   A released pad reads high, never the last level driven.
`timescale 1ns/1ps
module tmr8_pin_model (
  input  wire logic [1:0] pin_out_i,
  input  wire logic [1:0] pin_oe_i,
  output logic      [1:0] pad_o
);
  ////////////////////////////////////////////////////////////////////////////////
  // The pull-up keeps the simulator from settling a released pad to a stale value.
  assign pad_o = (pin_out_i & pin_oe_i) | ~pin_oe_i;
endmodule

// *** testbench/test_timer8_waveform_control.sv ***
// Purpose: Self-checking bench for the 8-bit timer waveform control block.
// Assumes: The t0 pin toggles every 8 clocks, so one external count is 16 clocks.
// Notes:   Periods are taken between the second and third event pulse.
`timescale 1ns/1ps
module test_timer8_waveform_control
  import tmr8_pkg::*;
;
  logic       clk_i;
  logic       rstn_i;
  logic       wr_i;
  logic       rd_i;
  logic       ext_clk_pin_i;
  logic       overflow_o;
  logic [2:0] addr_i;
  logic [7:0] wdata_i;
  logic [7:0] rdata_o;
  logic [1:0] port_dir_i;
  logic [1:0] port_data_i;
  logic [1:0] pin_out_o;
  logic [1:0] pin_oe_o;
  logic [1:0] match_o;
  logic [1:0] pad;
  logic [1:0] wv;
  logic [1:0] seen;
  logic [1:0] exp_pin;
  logic [1:0] exp_pad;
  int         hi_a;
  int         hi_b;
  int         err_total;
  int         n_checks;
  int         seed;
  int         rnd;
  int         i;
  int         modes[9] = '{0, 1, 2, 3, 5, 7, 7, 7, 7};
  int         sels[9]  = '{1, 1, 1, 1, 1, 2, 3, 6, 7};
  logic [1:0] codes[6] = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h1, 2'h0};

  tmr8_wave_ctrl dut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_clk_pin_i(ext_clk_pin_i),
    .port_dir_i(port_dir_i), .port_data_i(port_data_i), .pin_out_o(pin_out_o),
    .pin_oe_o(pin_oe_o), .match_o(match_o), .overflow_o(overflow_o));
  tmr8_pin_model pads (.pin_out_i(pin_out_o), .pin_oe_i(pin_oe_o), .pad_o(pad));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk_val(string what, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_cnt(string what, int exp, int got);
    n_checks++;
    if (got != exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(logic [2:0] a, logic [7:0] exp, string what);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    chk_val(what, exp, rdata_o);
  endtask

  // Model of the event period in clocks; the divider of the t0 pin is its full period of 16 clocks.
  function automatic int exp_period(int m, int sel);
    int top;
    int dv;
    top = (m == 2 || m >= 4) ? 9 : 255;
    dv  = (sel == 1) ? 1 : (sel == 2) ? 8 : (sel == 3) ? 64 : 16;
    if (m == 1 || m == 5) begin
      return 2 * top * dv;
    end
    return (top + 1) * dv;
  endfunction

  task automatic run_mode(int m, int sel);
    int p;
    int k;
    wr(TMR8_OFS_CTRL_B, 8'h00);
    wr(TMR8_OFS_COUNT, 8'h00);
    wr(TMR8_OFS_CTRL_A, {6'h00, 2'(m)});
    wr(TMR8_OFS_CTRL_B, {4'h0, 1'(m >> 2), 3'(sel)});
    for (k = 0; k < 3; k++) begin
      p = 0;
      do begin
        @(posedge clk_i);
        #1;
        p++;
      end while (((m == 2) ? match_o[0] : overflow_o) !== 1'b1 && p < 3000);
    end
    chk_cnt("event period", exp_period(m, sel), p);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial begin
    ext_clk_pin_i = 1'b0;
    forever #32 ext_clk_pin_i = ~ext_clk_pin_i;
  end

  initial begin
    #200000;
    err_total++;
    give_verdict();
  end

  initial begin
    seed = 32'h1f7116e6;
    {rstn_i, wr_i, rd_i, addr_i, wdata_i, port_dir_i, port_data_i} = '0;
    {err_total, n_checks} = '0;
    wv = 2'b00;
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(TMR8_OFS_CTRL_A, 8'h00, "ctrl a reset");
    rd(TMR8_OFS_CTRL_B, 8'h00, "ctrl b reset");
    // Forced matches with the counter stopped, so no real match can hide a fault.
    for (i = 0; i < 6; i++) begin
      rnd = $random(seed);
      @(posedge clk_i);
      port_dir_i  <= rnd[1:0];
      port_data_i <= rnd[3:2];
      wr(TMR8_OFS_CTRL_A, {codes[i], codes[i], 4'h0});
      wr(TMR8_OFS_CTRL_B, 8'hc0);
      seen = 2'b00;
      repeat (3) begin
        @(posedge clk_i);
        #1;
        seen |= match_o;
      end
      case (codes[i])
        2'h1: wv = ~wv;
        2'h2: wv = 2'b00;
        2'h3: wv = 2'b11;
        default: ;
      endcase
      exp_pin = (codes[i] == 2'h0) ? rnd[3:2] : wv;
      exp_pad = (exp_pin & rnd[1:0]) | ~rnd[1:0];
      chk_val("pin", exp_pin, pin_out_o);
      chk_val("pin enable", rnd[1:0], pin_oe_o);
      chk_val("pad", exp_pad, pad);
      chk_val("forced match", 8'h00, seen);
      rd(TMR8_OFS_CTRL_B, 8'h00, "force readback");
    end
    // Code 1 in PWM: A needs the mode high bit, B stays reserved; force is ignored.
    wr(TMR8_OFS_CTRL_A, 8'h53);
    repeat (3) @(posedge clk_i);
    #1;
    chk_val("pwm code1 low", rnd[3:2], pin_out_o);
    wr(TMR8_OFS_CTRL_B, 8'hc8);
    repeat (3) @(posedge clk_i);
    #1;
    chk_val("pwm code1 high", {rnd[3], wv[0]}, pin_out_o);
    wr(TMR8_OFS_CTRL_A, 8'hf0);
    repeat (3) @(posedge clk_i);
    #1;
    chk_val("reserved mode", rnd[3:2], pin_out_o);
    wr(TMR8_OFS_CTRL_B, 8'hff);
    rd(TMR8_OFS_CTRL_B, 8'h0f, "ctrl b masked");
    wr(TMR8_OFS_CTRL_A, 8'hff);
    rd(TMR8_OFS_CTRL_A, 8'hf3, "ctrl a masked");
    wr(3'h6, 8'hff);
    rd(3'h6, 8'h00, "unmapped");
    wr(TMR8_OFS_CTRL_A, 8'h00);
    wr(TMR8_OFS_CTRL_B, 8'h00);
    wr(TMR8_OFS_CMP_B, rnd[7:0]);
    rd(TMR8_OFS_CMP_B, rnd[7:0], "compare b buffer");
    wr(TMR8_OFS_CMP_A, 8'h09);
    rd(TMR8_OFS_CMP_A, 8'h09, "compare a buffer");
    for (i = 0; i < 9; i++) begin
      run_mode(modes[i], sels[i]);
    end
    // Compare equal to TOP: each channel holds the level its TOP action gives.
    run_mode(0, 1);
    wr(TMR8_OFS_CMP_A, 8'hff);
    wr(TMR8_OFS_CMP_B, 8'hff);
    @(posedge clk_i);
    port_dir_i <= 2'b11;
    wr(TMR8_OFS_CTRL_A, 8'hb3);
    repeat (300) @(posedge clk_i);
    for (i = 0; i < 6; i++) begin
      rnd = $random(seed);
      repeat (20 + rnd[7:0]) @(posedge clk_i);
      #1;
      chk_val("pwm at top", 8'h01, pin_out_o);
    end
    // A buffered compare below TOP: one full period holds 0x41 high cycles on channel A.
    wr(TMR8_OFS_CMP_A, 8'h40);
    repeat (300) @(posedge clk_i);
    hi_a = 0;
    hi_b = 0;
    repeat (256) begin
      @(posedge clk_i);
      #1;
      hi_a += pin_out_o[0];
      hi_b += pin_out_o[1];
    end
    chk_cnt("pwm high a", 32'h41, hi_a);
    chk_cnt("pwm high b", 32'h0, hi_b);
    give_verdict();
  end
endmodule
